// ==== common/lph_pkg.sv ====
// Purpose: Constants, field layout and carriers of the lane pattern, filter and power-down bank.
// Assumes: Wishbone classic, 32-bit data, register index = byte address / 4.
package lph_pkg;
    localparam int unsigned LPH_LANES   = 4;
    localparam int unsigned LPH_REG_W   = 16;
    localparam int unsigned LPH_MAX_RES = 16;
    localparam int unsigned LPH_PRBS_W  = 23;

    // Register indices; byte address is four times the index
    localparam logic [7:0] LPH_IDX_PATFILT = 8'h15;
    localparam logic [7:0] LPH_IDX_PAT34   = 8'h17;
    localparam logic [7:0] LPH_IDX_PDN     = 8'h18;
    localparam logic [7:0] LPH_IDX_AUX     = 8'h1c;
    localparam logic [7:0] LPH_IDX_STATUS  = 8'h1d;

    localparam logic [15:0] LPH_RST_PATFILT = 16'h0000;
    localparam logic [15:0] LPH_RST_PAT34   = 16'h0000;
    localparam logic [15:0] LPH_RST_PDN     = 16'h0000;
    localparam logic [15:0] LPH_RST_AUX     = 16'h0000;

    // Field positions
    localparam int unsigned LPH_PRBS_MSB    = 15;
    localparam int unsigned LPH_L1_CODE_LSB = 9;
    localparam int unsigned LPH_L2_CODE_LSB = 6;
    localparam int unsigned LPH_ROUND_BIT   = 5;
    localparam int unsigned LPH_K_LSB       = 1;
    localparam int unsigned LPH_HPF_EN_BIT  = 0;
    localparam int unsigned LPH_L3_CODE_LSB = 5;
    localparam int unsigned LPH_L4_CODE_LSB = 2;
    localparam int unsigned LPH_PDN_DIG_LSB = 12;
    localparam int unsigned LPH_PDN_LN_LSB  = 8;
    localparam int unsigned LPH_PDN_ANA_LSB = 4;
    localparam int unsigned LPH_INV_LSB     = 0;
    localparam int unsigned LPH_INDSEL_BIT  = 0;

    localparam logic [3:0] LPH_K_MIN = 4'h2;
    localparam logic [3:0] LPH_K_MAX = 4'ha;
    localparam logic [LPH_PRBS_W-1:0] LPH_PRBS_SEED = 23'h7fffff;

    typedef enum logic [2:0] {
        LPH_PAT_NORMAL = 3'h0,
        LPH_PAT_SYNC   = 3'h1,
        LPH_PAT_ALT    = 3'h2,
        LPH_PAT_CUSTOM = 3'h3,
        LPH_PAT_ONES   = 3'h4,
        LPH_PAT_TOGGLE = 3'h5,
        LPH_PAT_ZEROS  = 3'h6,
        LPH_PAT_RAMP   = 3'h7
    } lph_pat_t;

    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } lph_wb_req_t;

    typedef struct packed {
        logic                   valid;
        logic [LPH_MAX_RES-1:0] data;
    } lph_lane_t;
endpackage

// ==== design/lph_regs.sv ====
// Purpose: Lane pattern, high-pass filter and power-down register bank with its data path.
// Assumes: Samples are signed, in the low RES bits, on clk_i with a valid pulse.
// Notes:   Lane n carries channel n; one wait state on every bus access.
`timescale 1ns/1ps
`default_nettype none
module lph_regs #(
    parameter int unsigned RES  = 14,
    parameter int unsigned FRAC = 8
) (
    input  wire logic                                          clk_i,
    input  wire logic                                          rst_i,
    input  wire lph_pkg::lph_wb_req_t                          wb_i,
    output logic                                               wb_ack_o,
    output logic [31:0]                                        wb_dat_o,
    input  wire logic                                          sample_valid_i,
    input  wire logic [lph_pkg::LPH_LANES-1:0][lph_pkg::LPH_MAX_RES-1:0] sample_i,
    input  wire logic [lph_pkg::LPH_MAX_RES-1:0]               custom_pattern_i,
    output lph_pkg::lph_lane_t [lph_pkg::LPH_LANES-1:0]        lane_o,
    output logic [lph_pkg::LPH_LANES-1:0]                      dig_pdn_o,
    output logic [lph_pkg::LPH_LANES-1:0]                      ana_pdn_o,
    output logic [lph_pkg::LPH_LANES-1:0]                      lane_pdn_o
);
    import lph_pkg::*;

    localparam int unsigned AW = RES + FRAC + 4;

    if (RES < 8 || RES > LPH_MAX_RES || FRAC < 1 || FRAC > 12) begin : g_bad_param
        $error("lph_regs: RES must be 8..16 and FRAC 1..12");
    end

    // Register state
    logic [15:0] patfilt_q;
    logic [15:0] pat34_q;
    logic [15:0] pdn_q;
    logic [15:0] aux_q;
    logic        ack_q;
    logic [31:0] rdat_q;

    // Data path state
    logic signed [AW-1:0]         xp_q [LPH_LANES];
    logic signed [AW-1:0]         yp_q [LPH_LANES];
    logic [LPH_PRBS_W-1:0]        prbs_q [LPH_LANES];
    logic [RES-1:0]               ramp_q [LPH_LANES];
    logic [LPH_LANES-1:0]         toggle_q;
    lph_lane_t [LPH_LANES-1:0]    lane_q;

    function automatic logic [15:0] merge_bytes(input logic [15:0] old_v,
                                                input logic [31:0] new_v,
                                                input logic [3:0]  sel);
        logic [15:0] r;
        r = old_v;
        if (sel[0]) begin
            r[7:0] = new_v[7:0];
        end
        if (sel[1]) begin
            r[15:8] = new_v[15:8];
        end
        return r;
    endfunction

    function automatic logic signed [AW-1:0] widen(input logic [LPH_MAX_RES-1:0] x);
        logic signed [AW-1:0] r;
        r = AW'(signed'(x[RES-1:0]));
        return r <<< FRAC;
    endfunction

    function automatic logic [3:0] clamp_k(input logic [3:0] k);
        logic [3:0] r;
        r = k;
        if (k < LPH_K_MIN) begin
            r = LPH_K_MIN;
        end else if (k > LPH_K_MAX) begin
            r = LPH_K_MAX;
        end
        return r;
    endfunction

    // Scale by 2^k/(2^k+1) as 1 - 2^-k + 2^-2k
    function automatic logic signed [AW-1:0] hpf_step(input logic signed [AW-1:0] x,
                                                     input logic signed [AW-1:0] xp,
                                                     input logic signed [AW-1:0] yp,
                                                     input logic [3:0]           k);
        logic signed [AW-1:0] s;
        logic [4:0]           k2;
        s  = x - xp + yp;
        k2 = {k, 1'b0};
        return s - (s >>> k) + (s >>> k2);
    endfunction

    function automatic logic [RES-1:0] reduce(input logic signed [AW-1:0] y,
                                              input logic                 round_en);
        logic signed [AW-1:0] t;
        logic signed [AW-1:0] maxp;
        logic signed [AW-1:0] minn;
        maxp = AW'((64'sd1 <<< (RES - 1)) - 64'sd1);
        minn = -maxp - AW'(1);
        t = y;
        if (round_en) begin
            t = y + (AW'(1) <<< (FRAC - 1));
        end
        t = t >>> FRAC;
        if (t > maxp) begin
            t = maxp;
        end else if (t < minn) begin
            t = minn;
        end
        return t[RES-1:0];
    endfunction

    function automatic logic [LPH_PRBS_W-1:0] prbs_adv(input logic [LPH_PRBS_W-1:0] s);
        logic [LPH_PRBS_W-1:0] r;
        r = s;
        for (int i = 0; i < RES; i++) begin
            r = {r[LPH_PRBS_W-2:0], r[22] ^ r[17]};
        end
        return r;
    endfunction

    function automatic logic [RES-1:0] pat_word(input lph_pat_t       code,
                                                input logic [RES-1:0] normal,
                                                input logic [RES-1:0] custom,
                                                input logic           tog,
                                                input logic [RES-1:0] ramp);
        logic [RES-1:0] alt;
        logic [RES-1:0] r;
        for (int i = 0; i < RES; i++) begin
            alt[i] = i[0];
        end
        case (code)
            LPH_PAT_NORMAL: r = normal;
            LPH_PAT_SYNC:   r = {RES{1'b1}} << (RES / 2);
            LPH_PAT_ALT:    r = alt;
            LPH_PAT_CUSTOM: r = custom;
            LPH_PAT_ONES:   r = {RES{1'b1}};
            LPH_PAT_TOGGLE: r = tog ? ~alt : alt;
            LPH_PAT_ZEROS:  r = '0;
            LPH_PAT_RAMP:   r = ramp;
            default:        r = normal;
        endcase
        return r;
    endfunction

    // Decoded controls
    logic                 ind_sel;
    logic                 hpf_en;
    logic                 round_en;
    logic [3:0]           k_eff;
    logic [LPH_LANES-1:0] prbs_en;
    logic [LPH_LANES-1:0] inv_en;
    lph_pat_t             code [LPH_LANES];
    logic [15:0]          status;

    always_comb begin
        ind_sel  = aux_q[LPH_INDSEL_BIT];
        hpf_en   = patfilt_q[LPH_HPF_EN_BIT];
        round_en = patfilt_q[LPH_ROUND_BIT];
        k_eff    = clamp_k(patfilt_q[LPH_K_LSB +: 4]);
        inv_en   = pdn_q[LPH_INV_LSB +: LPH_LANES];
        for (int l = 0; l < LPH_LANES; l++) begin
            prbs_en[l] = ind_sel & patfilt_q[LPH_PRBS_MSB - l];
        end
        code[0] = LPH_PAT_NORMAL;
        code[1] = LPH_PAT_NORMAL;
        code[2] = LPH_PAT_NORMAL;
        code[3] = LPH_PAT_NORMAL;
        if (ind_sel) begin
            code[0] = lph_pat_t'(patfilt_q[LPH_L1_CODE_LSB +: 3]);
            code[1] = lph_pat_t'(patfilt_q[LPH_L2_CODE_LSB +: 3]);
            code[2] = lph_pat_t'(pat34_q[LPH_L3_CODE_LSB +: 3]);
            code[3] = lph_pat_t'(pat34_q[LPH_L4_CODE_LSB +: 3]);
        end
        for (int l = 0; l < LPH_LANES; l++) begin
            status[4*l +: 4] = {prbs_en[l], code[l]};
        end
    end

    // Wishbone classic slave
    logic        req;
    logic [7:0]  idx;

    always_comb begin
        req = wb_i.cyc & wb_i.stb;
        idx = {2'b00, wb_i.adr[7:2]};
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req & ~ack_q;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdat_q <= 32'h0000_0000;
        end else if (req & ~ack_q) begin
            case (idx)
                LPH_IDX_PATFILT: rdat_q <= {16'h0000, patfilt_q};
                LPH_IDX_PAT34:   rdat_q <= {16'h0000, pat34_q};
                LPH_IDX_PDN:     rdat_q <= {16'h0000, pdn_q};
                LPH_IDX_AUX:     rdat_q <= {16'h0000, aux_q};
                LPH_IDX_STATUS:  rdat_q <= {16'h0000, status};
                default:         rdat_q <= 32'h0000_0000;
            endcase
        end
    end

    // Writes commit on the edge where the master samples ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            patfilt_q <= LPH_RST_PATFILT;
            pat34_q   <= LPH_RST_PAT34;
            pdn_q     <= LPH_RST_PDN;
            aux_q     <= LPH_RST_AUX;
        end else if (req & wb_i.we & ack_q) begin
            case (idx)
                LPH_IDX_PATFILT: patfilt_q <= merge_bytes(patfilt_q, wb_i.dat, wb_i.sel);
                LPH_IDX_PAT34:   pat34_q   <= merge_bytes(pat34_q, wb_i.dat, wb_i.sel);
                LPH_IDX_PDN:     pdn_q     <= merge_bytes(pdn_q, wb_i.dat, wb_i.sel);
                LPH_IDX_AUX:     aux_q     <= merge_bytes(aux_q, wb_i.dat, wb_i.sel);
                default:         aux_q     <= aux_q;
            endcase
        end
    end

    // Filter and pattern path
    logic signed [AW-1:0] x_w [LPH_LANES];
    logic signed [AW-1:0] y_w [LPH_LANES];
    logic [RES-1:0]       norm_w [LPH_LANES];
    logic [RES-1:0]       word_w [LPH_LANES];
    logic [LPH_PRBS_W-1:0] prbs_w [LPH_LANES];

    always_comb begin
        for (int l = 0; l < LPH_LANES; l++) begin
            x_w[l]    = widen(sample_i[l]);
            y_w[l]    = hpf_step(x_w[l], xp_q[l], yp_q[l], k_eff);
            norm_w[l] = hpf_en ? reduce(y_w[l], round_en)
                               : sample_i[l][RES-1:0];
            prbs_w[l] = prbs_adv(prbs_q[l]);
            word_w[l] = prbs_en[l] ? prbs_w[l][RES-1:0]
                      : pat_word(code[l], norm_w[l],
                                 custom_pattern_i[RES-1:0], toggle_q[l], ramp_q[l]);
            if (inv_en[l]) begin
                word_w[l] = ~word_w[l];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            for (int l = 0; l < LPH_LANES; l++) begin
                xp_q[l] <= '0;
                yp_q[l] <= '0;
            end
        end else if (sample_valid_i) begin
            for (int l = 0; l < LPH_LANES; l++) begin
                // Filter state frozen while bypassed or digitally powered down
                if (hpf_en && !pdn_q[LPH_PDN_DIG_LSB + l]) begin
                    xp_q[l] <= x_w[l];
                    yp_q[l] <= y_w[l];
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            toggle_q <= '0;
            for (int l = 0; l < LPH_LANES; l++) begin
                prbs_q[l] <= LPH_PRBS_SEED;
                ramp_q[l] <= '0;
            end
        end else if (sample_valid_i) begin
            for (int l = 0; l < LPH_LANES; l++) begin
                if (!pdn_q[LPH_PDN_LN_LSB + l]) begin
                    toggle_q[l] <= ~toggle_q[l];
                    ramp_q[l]   <= ramp_q[l] + RES'(1);
                    if (prbs_en[l]) begin
                        prbs_q[l] <= prbs_w[l];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lane_q <= '0;
        end else begin
            for (int l = 0; l < LPH_LANES; l++) begin
                if (pdn_q[LPH_PDN_LN_LSB + l]) begin
                    lane_q[l] <= '0;
                end else if (pdn_q[LPH_PDN_DIG_LSB + l]) begin
                    lane_q[l].valid <= 1'b0;
                end else begin
                    lane_q[l].valid <= sample_valid_i;
                    if (sample_valid_i) begin
                        lane_q[l].data <= LPH_MAX_RES'(word_w[l]);
                    end
                end
            end
        end
    end

    always_comb begin
        wb_ack_o   = ack_q;
        wb_dat_o   = rdat_q;
        lane_o     = lane_q;
        dig_pdn_o  = pdn_q[LPH_PDN_DIG_LSB +: LPH_LANES];
        ana_pdn_o  = pdn_q[LPH_PDN_ANA_LSB +: LPH_LANES];
        lane_pdn_o = pdn_q[LPH_PDN_LN_LSB +: LPH_LANES];
    end
endmodule
`default_nettype wire

// ==== sim/lph_regs_chk.sv ====
// Purpose: Port-level checks of bus timing, power-down and lane outputs.
// Assumes: One wait state per access, as the bank answers.
// Notes:   Bound onto every bank instance.
`timescale 1ns/1ps
`default_nettype none
module lph_regs_chk #(
    parameter int unsigned RES = 14
) (
    input wire logic                                    clk_i,
    input wire logic                                    rst_i,
    input wire lph_pkg::lph_wb_req_t                    wb_i,
    input wire logic                                    wb_ack_o,
    input wire logic [31:0]                             wb_dat_o,
    input wire logic                                    sample_valid_i,
    input wire lph_pkg::lph_lane_t [lph_pkg::LPH_LANES-1:0] lane_o,
    input wire logic [lph_pkg::LPH_LANES-1:0]           dig_pdn_o,
    input wire logic [lph_pkg::LPH_LANES-1:0]           ana_pdn_o,
    input wire logic [lph_pkg::LPH_LANES-1:0]           lane_pdn_o
);
    import lph_pkg::*;
    logic pdn_wr;
    assign pdn_wr = wb_i.cyc && wb_i.stb && wb_i.we && wb_ack_o && wb_i.adr == 8'h60
        && wb_i.sel[1:0] == 2'h3;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_follows_req: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
        else $error("no ack one cycle after request");
    a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_has_req: assert property (wb_ack_o |-> $past(wb_i.cyc && wb_i.stb))
        else $error("ack without request");
    a_rdata_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_pdn_write_map: assert property (
        pdn_wr |=> {dig_pdn_o, lane_pdn_o, ana_pdn_o} == $past(wb_i.dat[15:4]))
        else $error("power-down outputs differ from written value");
    a_pdn_held: assert property (
        !$stable({dig_pdn_o, lane_pdn_o, ana_pdn_o}) |-> $past(wb_ack_o && wb_i.we))
        else $error("power-down outputs moved without a write");
    a_valid_from_sample: assert property (lane_o[2].valid |-> $past(sample_valid_i))
        else $error("lane valid without sample");
    a_dig_pdn_mute: assert property (
        dig_pdn_o[0] && $past(dig_pdn_o[0]) |-> !lane_o[0].valid)
        else $error("valid from powered-down channel");
    a_lane_pdn_zero: assert property (
        lane_pdn_o[1] && $past(lane_pdn_o[1]) && $past(lane_pdn_o[1], 2) |-> lane_o[1] == '0)
        else $error("powered-down lane not zero");
    a_lane_width: assert property ((lane_o[3].data >> RES) == '0)
        else $error("lane word above resolution not zero");
endmodule
bind lph_regs lph_regs_chk #(.RES(RES)) u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sample_valid_i(sample_valid_i),
    .lane_o(lane_o), .dig_pdn_o(dig_pdn_o), .ana_pdn_o(ana_pdn_o), .lane_pdn_o(lane_pdn_o));
`default_nettype wire

// ==== sim/testbench.sv ====
// Purpose: Self-checking bench of the lane pattern, filter and power-down bank.
// Assumes: RES 14; bus waits for ack under a bound.
// Notes:   Random values from a fixed-seed shift register.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import lph_pkg::*;
    localparam logic [15:0] MSK = 16'h3fff;
    logic                       clk_i = 1'b0;
    logic                       rst_i = 1'b1;
    lph_wb_req_t                wb_i = '0;
    logic                       wb_ack_o;
    logic [31:0]                wb_dat_o;
    logic                       sample_valid_i = 1'b0;
    logic [3:0][15:0]           sample_i = '0;
    logic [15:0]                custom_pattern_i = '0;
    lph_lane_t [3:0]            lane_o;
    logic [3:0]                 dig_pdn_o;
    logic [3:0]                 ana_pdn_o;
    logic [3:0]                 lane_pdn_o;
    int                         errors = 0;
    int                         compares = 0;
    logic [31:0]                rnd = 32'h3b63;
    logic [31:0]                rd;
    logic [15:0]                w1 [4];
    logic [7:0]                 ad [4] = '{8'h54, 8'h5c, 8'h60, 8'h7c};
    int                         y0;
    int                         y1;

    always #2.5 clk_i = ~clk_i;

    lph_regs #(.RES(14), .FRAC(8)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
        .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .sample_valid_i(sample_valid_i),
        .sample_i(sample_i), .custom_pattern_i(custom_pattern_i), .lane_o(lane_o),
        .dig_pdn_o(dig_pdn_o), .ana_pdn_o(ana_pdn_o), .lane_pdn_o(lane_pdn_o));

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    function automatic logic [15:0] exp_pat(input int c, input logic [15:0] x, prev);
        case (c)
            0: return x & MSK;
            1: return 16'h3f80;
            2: return 16'h2aaa;
            3: return custom_pattern_i & MSK;
            4: return MSK;
            5: return prev ^ MSK;
            6: return 16'h0000;
            default: return (prev + 16'h0001) & MSK;
        endcase
    endfunction

    // PRBS23 from an all-ones seed, 14 steps per sample
    function automatic logic [13:0] prbs_exp(input int n);
        logic [22:0] r;
        r = 23'h7fffff;
        for (int i = 0; i < 14 * n; i++) begin
            r = {r[21:0], r[22] ^ r[17]};
        end
        return r[13:0];
    endfunction

    task automatic final_report();
        if (errors == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] seen, exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic bus(input logic we, input logic [7:0] a, input logic [15:0] d,
                       input logic [3:0] s);
        int n;
        @(posedge clk_i);
        wb_i <= '{1'b1, 1'b1, we, a, s, {16'h0000, d}};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            errors++;
            final_report();
        end
        rd = wb_dat_o;
        wb_i <= '0;
    endtask

    task automatic smp(input logic [15:0] x);
        @(posedge clk_i);
        sample_valid_i <= 1'b1;
        sample_i <= {4{x}};
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        #1;
    endtask

    task automatic filt(input logic [15:0] x);
        smp(x);
        y0 = int'($signed(lane_o[0].data[13:0]));
        repeat (60) smp(x);
        y1 = int'($signed(lane_o[0].data[13:0]));
    endtask

    initial begin
        repeat (50000) @(posedge clk_i);
        errors++;
        final_report();
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 3; i++) begin
            bus(1'b0, ad[i], 16'h0, 4'hf);
            chk("reset_value", rd, 32'h0);
        end
        repeat (6) for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            bus(1'b1, ad[i], (i == 1) ? (rnd[15:0] & 16'h00fc) : rnd[15:0], 4'h3);
            if (i == 2) begin
                #1;
                chk("pdn_out", {dig_pdn_o, lane_pdn_o, ana_pdn_o}, rnd[15:4]);
            end
            bus(1'b0, ad[i], 16'h0, 4'hf);
            chk("readback", rd, (i == 3) ? 0 : (i == 1) ? rnd[15:0] & 16'h00fc : rnd[15:0]);
        end
        bus(1'b1, 8'h60, 16'h0000, 4'hf);
        bus(1'b1, 8'h60, 16'hffff, 4'h1);
        bus(1'b0, 8'h60, 16'h0, 4'hf);
        chk("byte_lane", rd, 32'h00ff);
        bus(1'b1, 8'h60, 16'h0000, 4'hf);
        bus(1'b1, 8'h70, 16'h0001, 4'hf);
        for (int c = 0; c < 8; c++) begin
            bus(1'b1, 8'h54, 16'((c << 9) | (c << 6)), 4'hf);
            bus(1'b1, 8'h5c, 16'((c << 5) | (c << 2)), 4'hf);
            bus(1'b0, 8'h74, 16'h0, 4'hf);
            chk("status_code", rd, {16'h0, {4{1'b0, c[2:0]}}});
            rnd = lfsr(rnd);
            custom_pattern_i <= rnd[31:16];
            smp(rnd[15:0]);
            for (int l = 0; l < 4; l++) w1[l] = lane_o[l].data;
            rnd = lfsr(rnd);
            smp(rnd[15:0]);
            for (int l = 0; l < 4; l++) chk("pattern", lane_o[l].data, exp_pat(c, rnd[15:0], w1[l]));
        end
        bus(1'b1, 8'h54, 16'h5800, 4'hf);
        bus(1'b1, 8'h5c, 16'h00c0, 4'hf);
        bus(1'b0, 8'h74, 16'h0, 4'hf);
        chk("status_prbs", rd, 32'h8684);
        bus(1'b1, 8'h60, 16'h1284, 4'hf);
        #1;
        chk("pdn_map", {dig_pdn_o, lane_pdn_o, ana_pdn_o}, 12'h128);
        smp(16'h1234);
        chk("dig_pdn_valid", lane_o[0].valid, 1'b0);
        chk("lane_pdn_zero", lane_o[1], 17'h0);
        chk("invert", {lane_o[2].valid, lane_o[2].data}, {1'b1, MSK});
        chk("prbs_first", {lane_o[3].valid, lane_o[3].data}, {1'b1, 2'b00, prbs_exp(1)});
        smp(16'h0000);
        chk("prbs_second", lane_o[3].data, {2'b00, prbs_exp(2)});
        bus(1'b1, 8'h60, 16'h0000, 4'hf);
        bus(1'b1, 8'h70, 16'h0000, 4'hf);
        bus(1'b1, 8'h54, 16'h0004, 4'hf);
        smp(16'd1000);
        chk("bypass", lane_o[0].data, 16'd1000);
        bus(1'b1, 8'h54, 16'h0005, 4'hf);
        filt(16'd1000);
        chk("hpf_k2", {y0 > 700 && y0 < 900, y1 < 5 && y1 > -5}, 2'h3);
        bus(1'b1, 8'h54, 16'h0035, 4'hf);
        filt(16'hfc18);
        chk("hpf_k10", {y0 < -1800 && y0 > -2200, y1 < -1500}, 2'h3);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(1'b0, 8'h54, 16'h0, 4'hf);
        chk("mid_reset", rd, 32'h0);
        final_report();
    end
endmodule
`default_nettype wire
